//--- hdl/wsw_core.sv
// Purpose: watchdog timer, shared prescaler and power-down control
// Assumes: pins and the RC oscillator arrive asynchronous to sys_clk_i
// Notes: sys_clk_i stands in for the main oscillator; core clock is gated
//
// Behaviour
// - watchdog counts ticks of its own RC oscillator, not the main clock.
// - time-out while running gives a full device reset, cause recorded.
// - time-out during power-down wakes the core at the next instruction.
// - a watchdog time-out outside the crystal start-up wait clears the active-low time-out flag.
// - cleared enable fuse disables the watchdog permanently.
// - one prescaler serves watchdog or timer, chosen by prescale register.
// - clear or sleep instruction clears watchdog and its assigned postscaler.
// - clear instruction clears the prescaler count only while assigned to the watchdog, never its assignment.
// - sleep clears watchdog, clears power-down flag, sets time-out flag.
// - pins are frozen in their last state during power-down.
// - wake on master clear, watchdog time-out, or interrupt sources.
// - master clear in power-down resets; other wakes continue execution.
// - power-down flag set at power-up, cleared by the sleep instruction.
// - listed peripheral interrupts may wake the device.
// - interrupt entry pushes only the return program counter.
// - crystal modes wait 1024 oscillator cycles after a watchdog or interrupt wake-up.
// - interrupt wake with global enable loads the interrupt vector.
`timescale 1ns/1ps
module wsw_core #(
   parameter int WDT_BASE_TICKS = 256,
   parameter int PERIPH_N = 6
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // avalon-mm slave
   input wire logic [wsw_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // pins and straps
   input wire logic master_clear_n_i,
   input wire logic wdt_rc_osc_i,
   input wire logic ext_int_i,
   input wire logic portb_change_i,
   input wire logic [PERIPH_N-1:0] periph_wake_i,
   input wire logic watchdog_enable_fuse_i,
   input wire logic crystal_mode_i,
   // core side
   input wire logic watchdog_clear_instruction_i,
   input wire logic sleep_instruction_i,
   input wire logic global_interrupt_enable_i,
   input wire logic [wsw_pkg::PC_W-1:0] pc_i,
   input wire logic timer0_tick_i,
   output logic timer0_inc_o,
   output logic core_reset_o,
   output logic core_clock_run_o,
   output logic osc_driver_on_o,
   output logic io_hold_o,
   output logic resume_o,
   output logic vector_load_o,
   output logic [wsw_pkg::PC_W-1:0] vector_addr_o,
   output logic stack_push_o,
   output logic [wsw_pkg::PC_W-1:0] stack_data_o,
   output logic timeout_flag_n_o,
   output logic powerdown_flag_n_o,
   output logic irq_o
);

   localparam int CNT_W = $clog2(WDT_BASE_TICKS);
   localparam int SYN_N = PERIPH_N + 4;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WDT_BASE_TICKS - 1);
   localparam logic [wsw_pkg::TMR_W-1:0] WARMUP_LAST = wsw_pkg::TMR_W'(wsw_pkg::WARMUP_CYCLES - 1);
   localparam logic [wsw_pkg::TMR_W-1:0] HOLD_LAST = wsw_pkg::TMR_W'(wsw_pkg::RST_HOLD_CYC - 1);

   // refuse settings the counters cannot serve
   generate
      if (WDT_BASE_TICKS < 2 || PERIPH_N < 1) begin : g_bad_param
         $error("wsw_core: WDT_BASE_TICKS must be at least 2, PERIPH_N at least 1");
      end
   endgenerate

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [SYN_N-1:0] pin_raw;
   logic [SYN_N-1:0] sync1_r;
   logic [SYN_N-1:0] sync2_r;
   logic rc_prev_r;
   logic master_clear_n;
   logic rc_tick;
   logic int_wake;

   assign pin_raw = {periph_wake_i, portb_change_i, ext_int_i, wdt_rc_osc_i, master_clear_n_i};

   // two flops per pin before any logic looks at it
   genvar gi;
   generate
      for (gi = 0; gi < SYN_N; gi++) begin : g_sync
         always_ff @(posedge sys_clk_i) begin
            if (!reset_n_i) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   // rising edge of the watchdog rc oscillator
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rc_prev_r <= 1'b0;
      end else begin
         rc_prev_r <= sync2_r[1];
      end
   end

   assign master_clear_n = sync2_r[0];
   assign rc_tick = sync2_r[1] & ~rc_prev_r;
   assign int_wake = |sync2_r[SYN_N-1:2];

   // ----------------------------------------------------------------
   // straps caught once after reset release
   // ----------------------------------------------------------------
   logic strap_done_r;
   logic fuse_r;
   logic crystal_r;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         strap_done_r <= 1'b0;
         fuse_r <= 1'b0;
         crystal_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         fuse_r <= watchdog_enable_fuse_i;
         crystal_r <= crystal_mode_i;
      end
   end

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic wait_r;
   logic req;
   logic acc;
   logic wr_acc;
   logic [7:0] opt_r;
   logic [wsw_pkg::EV_W-1:0] evt_r;
   logic [wsw_pkg::EV_W-1:0] mask_r;
   logic [wsw_pkg::EV_W-1:0] evt_set;
   logic [wsw_pkg::EV_W-1:0] evt_clr;
   logic to_n_r;
   logic pdown_n_r;
   wsw_pkg::wsw_state_t state_r;
   wsw_pkg::wsw_state_t state_nxt;

   assign req = avs_read_i | avs_write_i;
   assign acc = req & ~wait_r; // request completes on this edge
   assign wr_acc = acc & avs_write_i & avs_byteenable_i[0];

   // one wait cycle, then the answer
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~(req & wait_r);
      end
   end

   // read data prepared on the edge that drops waitrequest
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && wait_r) begin
         if (avs_address_i == wsw_pkg::FLAG_ADDR) begin
            avs_readdata_o <= 32'({to_n_r, pdown_n_r});
         end else if (avs_address_i == wsw_pkg::EVT_ADDR) begin
            avs_readdata_o <= 32'(evt_r);
         end else if (avs_address_i == wsw_pkg::MASK_ADDR) begin
            avs_readdata_o <= 32'(mask_r);
         end else if (avs_address_i == wsw_pkg::INFO_ADDR) begin
            avs_readdata_o <= 32'({crystal_r, fuse_r, state_r});
         end else if (avs_address_i == wsw_pkg::OPT_ADDR) begin
            avs_readdata_o <= 32'(opt_r);
         end else begin
            avs_readdata_o <= 32'h0000_0000;
         end
      end
   end

   // prescale register; assignment changes only by software write
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         opt_r <= wsw_pkg::OPT_RESET;
      end else if (wr_acc && avs_address_i == wsw_pkg::OPT_ADDR) begin
         opt_r <= avs_writedata_i[7:0];
      end
   end

   // interrupt mask
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         mask_r <= wsw_pkg::EV_RESET;
      end else if (wr_acc && avs_address_i == wsw_pkg::MASK_ADDR) begin
         mask_r <= avs_writedata_i[wsw_pkg::EV_W-1:0];
      end
   end

   assign evt_clr = (wr_acc && avs_address_i == wsw_pkg::EVT_ADDR) ?
                    avs_writedata_i[wsw_pkg::EV_W-1:0] : wsw_pkg::EV_RESET;

   // sticky events, a new event beats a write-one clear
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         evt_r <= wsw_pkg::EV_RESET;
         irq_o <= 1'b0;
      end else begin
         evt_r <= (evt_r & ~evt_clr) | evt_set;
         irq_o <= |(evt_r & mask_r);
      end
   end

   assign avs_waitrequest_o = wait_r;

   // ----------------------------------------------------------------
   // watchdog counter and shared prescaler
   // ----------------------------------------------------------------
   logic presc_wdt;
   logic [wsw_pkg::OPT_PS_W-1:0] ps;
   logic [CNT_W-1:0] wdt_cnt_r;
   logic [7:0] presc_r;
   logic [8:0] ratio;
   logic presc_last;
   logic presc_in;
   logic base_to;
   logic wdt_clr;
   logic wdt_to;

   assign presc_wdt = opt_r[wsw_pkg::OPT_ASSIGN_BIT];
   assign ps = opt_r[wsw_pkg::OPT_PS_LSB +: wsw_pkg::OPT_PS_W];
   // postscaler 1:2^ps on the watchdog, 1:2^(ps+1) on the timer
   assign ratio = presc_wdt ? (9'h001 << ps) : (9'h002 << ps);
   assign presc_last = presc_r == 8'(ratio - 9'h001);
   assign wdt_clr = watchdog_clear_instruction_i | sleep_instruction_i |
                    ~fuse_r | (state_r == wsw_pkg::ST_RST);
   assign base_to = rc_tick & (wdt_cnt_r == CNT_LAST);
   assign presc_in = presc_wdt ? base_to : timer0_tick_i;
   // no time-out at all with the fuse cleared
   assign wdt_to = fuse_r & ~wdt_clr & base_to & (~presc_wdt | presc_last);

   // base count of rc oscillator ticks
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wdt_cnt_r <= '0;
      end else if (wdt_clr) begin
         wdt_cnt_r <= '0;
      end else if (rc_tick) begin
         wdt_cnt_r <= base_to ? '0 : wdt_cnt_r + 1'b1;
      end
   end

   // prescaler count; cleared with the watchdog only when assigned to it
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         presc_r <= 8'h00;
      end else if (presc_wdt && wdt_clr) begin
         presc_r <= 8'h00;
      end else if (presc_in) begin
         presc_r <= presc_last ? 8'h00 : presc_r + 8'h01;
      end
   end

   // timer increment, after the prescaler only while it is assigned to the timer
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         timer0_inc_o <= 1'b0;
      end else begin
         timer0_inc_o <= presc_wdt ? timer0_tick_i : (timer0_tick_i & presc_last);
      end
   end

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   logic [wsw_pkg::TMR_W-1:0] tmr_r;
   logic wake_int_r;
   logic resume;

   always_comb begin
      state_nxt = state_r;
      evt_set = wsw_pkg::EV_RESET;
      resume = 1'b0;
      case (state_r)
         wsw_pkg::ST_RUN: begin
            if (!master_clear_n) begin
               state_nxt = wsw_pkg::ST_RST;
               evt_set[wsw_pkg::EV_MASTER_CLR] = 1'b1;
            end else if (wdt_to) begin
               state_nxt = wsw_pkg::ST_RST;
               evt_set[wsw_pkg::EV_WDT_RST] = 1'b1;
            end else if (sleep_instruction_i) begin
               state_nxt = wsw_pkg::ST_SLEEP;
            end
         end
         wsw_pkg::ST_SLEEP: begin
            if (!master_clear_n) begin
               state_nxt = wsw_pkg::ST_RST;
               evt_set[wsw_pkg::EV_MASTER_CLR] = 1'b1;
            end else if (wdt_to || int_wake) begin
               state_nxt = crystal_r ? wsw_pkg::ST_WARMUP : wsw_pkg::ST_RUN;
               resume = ~crystal_r;
               evt_set[wsw_pkg::EV_WDT_WAKE] = wdt_to;
               evt_set[wsw_pkg::EV_INT_WAKE] = ~wdt_to;
            end
         end
         wsw_pkg::ST_WARMUP: begin
            if (!master_clear_n) begin
               state_nxt = wsw_pkg::ST_RST;
               evt_set[wsw_pkg::EV_MASTER_CLR] = 1'b1;
            end else if (tmr_r == WARMUP_LAST) begin
               state_nxt = wsw_pkg::ST_RUN;
               resume = 1'b1;
            end
         end
         wsw_pkg::ST_RST: begin
            if (master_clear_n && tmr_r == HOLD_LAST) begin
               state_nxt = wsw_pkg::ST_RUN;
            end
         end
         default: begin
            state_nxt = wsw_pkg::ST_RST;
         end
      endcase
   end

   // state register; power-up starts in reset hold
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         state_r <= wsw_pkg::ST_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // start-up and reset hold timer, restarts on each state change
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         tmr_r <= '0;
      end else if (state_nxt != state_r || !master_clear_n) begin
         tmr_r <= '0;
      end else if (tmr_r != WARMUP_LAST) begin
         tmr_r <= tmr_r + 1'b1;
      end
   end

   // remembers whether an interrupt caused the wake
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wake_int_r <= 1'b0;
      end else if (state_r == wsw_pkg::ST_SLEEP && state_nxt != state_r) begin
         wake_int_r <= ~wdt_to & int_wake;
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         to_n_r <= 1'b1;
         pdown_n_r <= 1'b1;
      end else if (wdt_to && state_r != wsw_pkg::ST_WARMUP) begin
         to_n_r <= 1'b0;
      end else if (state_r == wsw_pkg::ST_RUN && master_clear_n && sleep_instruction_i) begin
         to_n_r <= 1'b1;
         pdown_n_r <= 1'b0;
      end else if (state_r == wsw_pkg::ST_RUN && watchdog_clear_instruction_i) begin
         to_n_r <= 1'b1;
         pdown_n_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // outputs to the core
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         core_reset_o <= 1'b1;
         core_clock_run_o <= 1'b0;
         osc_driver_on_o <= 1'b1;
         io_hold_o <= 1'b0;
         timeout_flag_n_o <= 1'b1;
         powerdown_flag_n_o <= 1'b1;
      end else begin
         core_reset_o <= state_nxt == wsw_pkg::ST_RST;
         core_clock_run_o <= state_nxt == wsw_pkg::ST_RUN;
         osc_driver_on_o <= state_nxt != wsw_pkg::ST_SLEEP;
         io_hold_o <= state_nxt == wsw_pkg::ST_SLEEP ||
                      state_nxt == wsw_pkg::ST_WARMUP;
         timeout_flag_n_o <= to_n_r;
         powerdown_flag_n_o <= pdown_n_r;
      end
   end

   // resume pulse; interrupt wake with global enable enters the vector
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         resume_o <= 1'b0;
         vector_load_o <= 1'b0;
         vector_addr_o <= '0;
         stack_push_o <= 1'b0;
         stack_data_o <= '0;
      end else begin
         resume_o <= resume;
         vector_load_o <= resume & global_interrupt_enable_i &
                          (state_r == wsw_pkg::ST_WARMUP ? wake_int_r : ~wdt_to);
         stack_push_o <= resume & global_interrupt_enable_i &
                         (state_r == wsw_pkg::ST_WARMUP ? wake_int_r : ~wdt_to);
         vector_addr_o <= wsw_pkg::INT_VECTOR;
         stack_data_o <= pc_i + wsw_pkg::PC_STEP;
      end
   end

endmodule

//--- pkg/wsw_pkg.sv
// Purpose: shared constants and types of the watchdog and sleep controller
// Assumes: 40 MHz system clock, 32-bit Avalon-MM register port
// Notes: byte address of the prescale register is four times its index
package wsw_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [7:0] OPT_IDX = 8'h81;
   localparam logic [ADDR_W-1:0] OPT_ADDR = {2'h0, OPT_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] FLAG_ADDR = 12'h000;
   localparam logic [ADDR_W-1:0] EVT_ADDR = 12'h004;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h008;
   localparam logic [ADDR_W-1:0] INFO_ADDR = 12'h00C;

   // ----------------------------------------------------------------
   // field layouts and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] OPT_RESET = 8'hFF;
   localparam int OPT_ASSIGN_BIT = 3;
   localparam int OPT_PS_LSB = 0;
   localparam int OPT_PS_W = 3;
   localparam int FLAG_POWERDOWN_BIT = 0;
   localparam int FLAG_TO_BIT = 1;
   localparam int EV_WDT_RST = 0;
   localparam int EV_WDT_WAKE = 1;
   localparam int EV_INT_WAKE = 2;
   localparam int EV_MASTER_CLR = 3;
   localparam int EV_W = 4;
   localparam logic [EV_W-1:0] EV_RESET = 4'h0;

   // ----------------------------------------------------------------
   // program counter values
   // ----------------------------------------------------------------
   localparam int PC_W = 13;
   localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
   localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int WARMUP_CYCLES = 1024;
   localparam int RST_HOLD_NS = 400;
   localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 11;

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_SLEEP = 4'h2,
      ST_WARMUP = 4'h4,
      ST_RST = 4'h8
   } wsw_state_t;

endpackage

//--- test/wsw_core_asserts.sv
// Purpose: port-level checks on the watchdog and sleep controller
// Assumes: straps change only while reset is low
// Notes: bound into wsw_core below the module
`timescale 1ns/1ps
module wsw_core_chk (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // bus handshake
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   // core side
   input wire logic watchdog_enable_fuse_i,
   input wire logic watchdog_clear_instruction_i,
   input wire logic sleep_instruction_i,
   input wire logic global_interrupt_enable_i,
   input wire logic core_reset_o,
   input wire logic core_clock_run_o,
   input wire logic osc_driver_on_o,
   input wire logic io_hold_o,
   input wire logic resume_o,
   input wire logic vector_load_o,
   input wire logic [wsw_pkg::PC_W-1:0] vector_addr_o,
   input wire logic stack_push_o,
   input wire logic timeout_flag_n_o,
   input wire logic powerdown_flag_n_o
);
   // -----------------------------------------------------------
   // properties
   // -----------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_SLEEP_FLAGS: assert property (sleep_instruction_i && core_clock_run_o |->
      ##2 !powerdown_flag_n_o && timeout_flag_n_o) else $error("sleep flags wrong");
   AST_SLEEP_OSC: assert property (sleep_instruction_i && core_clock_run_o |=>
      !osc_driver_on_o && io_hold_o) else $error("sleep entry wrong");
   AST_TO_CAUSE: assert property ($fell(timeout_flag_n_o) |->
      core_reset_o || $past(io_hold_o, 2)) else $error("time-out without reset or wake");
   AST_FUSE_OFF: assert property (!watchdog_enable_fuse_i |->
      !$fell(timeout_flag_n_o)) else $error("disabled watchdog timed out");
   AST_VECTOR: assert property (stack_push_o |-> vector_load_o && resume_o &&
      vector_addr_o == wsw_pkg::INT_VECTOR) else $error("vector entry wrong");
   AST_VEC_GLB: assert property (vector_load_o |-> $past(global_interrupt_enable_i))
      else $error("vector without global enable");
   AST_CLR_FLAGS: assert property (watchdog_clear_instruction_i && core_clock_run_o |->
      ##2 timeout_flag_n_o && powerdown_flag_n_o) else $error("clear left flags low");
   AST_OSC_ON: assert property (!io_hold_o |-> osc_driver_on_o)
      else $error("oscillator off outside sleep");
   AST_RESUME: assert property (resume_o |-> core_clock_run_o && !core_reset_o && !io_hold_o)
      else $error("resume while held");
   AST_BUS_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("bus answer late");
endmodule

bind wsw_core wsw_core_chk u_chk (.sys_clk_i, .reset_n_i, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o, .watchdog_enable_fuse_i, .watchdog_clear_instruction_i,
   .sleep_instruction_i, .global_interrupt_enable_i, .core_reset_o, .core_clock_run_o,
   .osc_driver_on_o, .io_hold_o, .resume_o, .vector_load_o, .vector_addr_o, .stack_push_o,
   .timeout_flag_n_o, .powerdown_flag_n_o);

//--- test/testbench.sv
// Purpose: self-checking bench for the watchdog and sleep controller
// Assumes: short watchdog base count of 4 rc ticks
// Notes: rc oscillator made from a divider of the bench clock
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge clk); n++; end \
   if (n >= 3000) begin errors++; $display("MISMATCH t=%0t wait ran out", $time); wrap_up(); end end
module testbench;
   localparam logic [11:0] OPT = wsw_pkg::OPT_ADDR;
   localparam logic [11:0] FLG = wsw_pkg::FLAG_ADDR;
   localparam logic [11:0] EVT = wsw_pkg::EVT_ADDR;
   localparam logic [11:0] MSK = wsw_pkg::MASK_ADDR;
   logic clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0, ext_rst_n = 1'h1, fuse = 1'h1;
   logic xtal = 1'h0, clr = 1'h0, slp = 1'h0, global_interrupt_enable = 1'h0, tick = 1'h0, rc_en = 1'h0;
   logic [2:0] rc_cnt = 3'h0;
   logic [7:0] wake = 8'h00;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0, q, rdata;
   logic [12:0] pc = 13'h0100, vaddr, sdata;
   logic wreq, t0inc, core_rst, run, osc_on, hold, resume, vload, push, to_n, pdown_n, irq;
   int errors = 0, cmp_count = 0, n, k;

   // -----------------------------------------------------------
   // clock, rc oscillator and design
   // -----------------------------------------------------------
   always #12.5 clk = ~clk;
   always @(posedge clk) if (rc_en) rc_cnt <= rc_cnt + 3'h1;
   wsw_core #(.WDT_BASE_TICKS(4), .PERIPH_N(6)) dut (.sys_clk_i(clk), .reset_n_i(rst_n),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .master_clear_n_i(ext_rst_n), .wdt_rc_osc_i(rc_cnt[2]), .ext_int_i(wake[0]),
      .portb_change_i(wake[1]), .periph_wake_i(wake[7:2]), .watchdog_enable_fuse_i(fuse),
      .crystal_mode_i(xtal), .watchdog_clear_instruction_i(clr), .sleep_instruction_i(slp),
      .global_interrupt_enable_i(global_interrupt_enable), .pc_i(pc), .timer0_tick_i(tick), .timer0_inc_o(t0inc),
      .core_reset_o(core_rst), .core_clock_run_o(run), .osc_driver_on_o(osc_on),
      .io_hold_o(hold), .resume_o(resume), .vector_load_o(vload), .vector_addr_o(vaddr),
      .stack_push_o(push), .stack_data_o(sdata), .timeout_flag_n_o(to_n),
      .powerdown_flag_n_o(pdown_n), .irq_o(irq));

   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task wrap_up;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one bus transfer held until waitrequest is sampled low
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; rd <= !w; wr <= w;
      `WAITC(n > 0 && wreq === 1'h0)
      q = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      `CHK(q, e)
   endtask
   task do_reset(input logic f, input logic x);
      rst_n <= 1'h0; fuse <= f; xtal <= x;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      `WAITC(run === 1'h1)
   endtask
   task do_clear;
      @(posedge clk) clr <= 1'h1;
      @(posedge clk) clr <= 1'h0;
   endtask
   task do_sleep;
      @(posedge clk) slp <= 1'h1;
      @(posedge clk) slp <= 1'h0;
      @(posedge clk);
   endtask
   task wake_on(input logic [7:0] s);
      do_sleep;
      wake <= s;
      `WAITC(resume === 1'h1)
   endtask

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      do_reset(1'h1, 1'h0);
      rd_chk(OPT, 32'hFF);
      rd_chk(FLG, 32'h3);
      rd_chk(12'h100, 32'h0);
      bus(1'h1, OPT, 32'h0);
      rd_chk(OPT, 32'h0);
      // prescaler on the timer at 1:2
      k = 0;
      repeat (16) begin @(posedge clk); tick <= !tick; k += t0inc; end
      @(posedge clk) k += t0inc;
      `CHK(k, 4)
      // clears keep the watchdog quiet, then it bites
      rc_en <= 1'h1;
      repeat (12) begin do_clear; repeat (4) @(posedge clk); `CHK(core_rst, 1'h0) end
      `WAITC(core_rst === 1'h1)
      rc_en <= 1'h0;
      @(posedge clk);
      `CHK(to_n, 1'h0)
      `WAITC(run === 1'h1)
      rd_chk(EVT, 32'h1);
      rd_chk(FLG, 32'h1);
      bus(1'h1, MSK, 32'h1);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'h1)
      bus(1'h1, EVT, 32'h1);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'h0)
      // sleep entry and interrupt wakes
      bus(1'h1, OPT, 32'h0);
      global_interrupt_enable <= 1'h1;
      do_sleep;
      @(posedge clk);
      `CHK({pdown_n, to_n, osc_on, hold}, 4'h5)
      wake <= 8'h01;
      `WAITC(resume === 1'h1)
      `CHK({vload, push, vaddr, sdata}, {2'h3, wsw_pkg::INT_VECTOR, 13'h0101})
      wake <= 8'h00;
      repeat (4) @(posedge clk);
      rd_chk(EVT, 32'h4);
      `CHK(irq, 1'h0)
      for (int i = 1; i < 8; i++) begin
         wake_on(8'h01 << i);
         wake <= 8'h00;
         repeat (4) @(posedge clk);
      end
      bus(1'h1, EVT, 32'hF);
      // watchdog wake without global enable
      global_interrupt_enable <= 1'h0;
      rc_en <= 1'h1;
      do_sleep;
      `WAITC(resume === 1'h1)
      rc_en <= 1'h0;
      `CHK({vload, core_rst}, 2'h0)
      rd_chk(FLG, 32'h0);
      rd_chk(EVT, 32'h2);
      do_clear;
      rd_chk(FLG, 32'h3);
      rd_chk(OPT, 32'h0);
      bus(1'h1, EVT, 32'hF);
      // master clear during sleep resets
      do_sleep;
      ext_rst_n <= 1'h0;
      `WAITC(core_rst === 1'h1)
      ext_rst_n <= 1'h1;
      `WAITC(run === 1'h1)
      rd_chk(EVT, 32'h8);
      // fuse off and crystal start-up wait
      do_reset(1'h0, 1'h1);
      bus(1'h1, OPT, 32'h0);
      rc_en <= 1'h1;
      repeat (100) @(posedge clk);
      `CHK({core_rst, to_n}, 2'h1)
      do_sleep;
      repeat (100) @(posedge clk);
      `CHK(hold, 1'h1)
      wake <= 8'h01;
      `WAITC(resume === 1'h1)
      `CHK(n >= 1024 && n < 1040, 1'h1)
      wake <= 8'h00;
      wrap_up;
   end
endmodule
